// >>> logic/cs_timing_defs.svh
`ifndef CS_TIMING_DEFS_SVH
`define CS_TIMING_DEFS_SVH

// Acknowledge-timing field encodings
`define ACK_FIELD_W      4
`define ACK_FIELD_FAST   4'he
`define ACK_FIELD_EXT    4'hf

// Byte-select field encodings
`define BYTE_SEL_OFF     2'h0
`define BYTE_SEL_ADDR0   2'h1
`define BYTE_SEL_ADDR1   2'h2
`define BYTE_SEL_BOTH    2'h3

// Byte count codes
`define SIZE_LONG        2'h0
`define SIZE_BYTE        2'h1
`define SIZE_WORD        2'h2
`define SIZE_THREE       2'h3

// Output reset values
`define CS_N_RESET       1'b1
`define ACK_RESET        1'b0

`endif

// >>> logic/cs_timing_pkg.sv
package cs_timing_pkg;

    // Cycle sequencer states
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_WAIT      = 3'b001,
        ST_EXT       = 3'b010,
        ST_HOLD      = 3'b011,
        ST_E_CLOCK_OUT_PEND = 3'b100,
        ST_E_CLOCK_OUT_RUN  = 3'b101
    } cycle_state_e;

    typedef logic [3:0] ack_field_t;

endpackage

// >>> logic/wait_count_if.sv
`timescale 1ns/1ps
`default_nettype none

// Link between sequencer and shared wait-state counter
interface wait_count_if #(parameter int WIDTH = 4);
    logic             load;
    logic [WIDTH-1:0] value;
    logic             dec;
    logic             zero;

    modport ctrl (output load, output value, output dec, input zero);
    modport cnt  (input load, input value, input dec, output zero);
endinterface

`default_nettype wire

// >>> logic/wait_counter.sv
`timescale 1ns/1ps
`default_nettype none

module wait_counter #(
    parameter int WIDTH = 4
) (
    input  wire logic   clk_in,
    input  wire logic   rst_in,
    wait_count_if.cnt   ws
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // Load wins over decrement; holds at zero
    always_comb begin
        count_next = count_reg;
        if (ws.load) begin
            count_next = ws.value;
        end else if (ws.dec && count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Expiry flag
    assign ws.zero = (count_reg == '0);

endmodule

`default_nettype wire

// >>> logic/cs_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "cs_timing_defs.svh"

module cs_timing
    import cs_timing_pkg::*;
#(
    parameter int CHANNELS = 12
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic [CHANNELS-1:0]   match_in,
    input  wire logic [CHANNELS-1:0]   mode_e_clock_out_in,
    input  wire logic [CHANNELS-1:0]   strobe_select_in,
    input  wire logic [CHANNELS*4-1:0] ack_timing_in,
    input  wire logic [CHANNELS-1:0]   autovector_en_in,
    input  wire logic [CHANNELS-1:0]   port16_in,
    input  wire logic [CHANNELS*2-1:0] byte_select_in,
    input  wire logic                  address_strobe_in,
    input  wire logic                  data_strobe_in,
    input  wire logic                  addr0_in,
    input  wire logic [1:0]            byte_count_code_in,
    input  wire logic                  iack_cycle_in,
    input  wire logic                  e_clock_out_ready_in,
    input  wire logic                  e_clock_out_done_in,
    input  wire logic                  next_part_in,
    input  wire logic                  ext_ack_word_n_in,
    input  wire logic                  ext_ack_byte_n_in,
    output logic [CHANNELS-1:0]        cs_n_out,
    output logic                       ack_word_port_out,
    output logic                       ack_byte_port_out,
    output logic                       autovector_request_out,
    output logic                       e_clock_out_pending_out,
    output logic                       cycle_end_out,
    output logic                       fast_cycle_out,
    output logic                       lane_upper_out,
    output logic                       lane_lower_out
);

    localparam int IDX_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

    // Elaboration check on channel count
    if (CHANNELS < 1 || CHANNELS > 16) begin : g_bad_channels
        $error("cs_timing: CHANNELS must be 1 to 16");
    end

    // External acknowledge pins, two-stage synchronisers
    logic [1:0] ack_meta_reg;
    logic [1:0] ack_sync_reg;
    logic       ext_ack;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_meta_reg <= 2'h3;
            ack_sync_reg <= 2'h3;
        end else begin
            ack_meta_reg <= {ext_ack_word_n_in, ext_ack_byte_n_in};
            ack_sync_reg <= ack_meta_reg;
        end
    end

    assign ext_ack = ~(&ack_sync_reg);

    // Byte-select gating of each channel's match
    logic [CHANNELS-1:0] hit;

    always_comb begin
        logic [1:0] bsel;
        bsel = 2'h0;
        hit  = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            bsel = byte_select_in[i*2 +: 2];
            if (bsel == `BYTE_SEL_OFF) begin
                hit[i] = 1'b0;
            end else if (!port16_in[i]) begin
                hit[i] = match_in[i];
            end else begin
                case (bsel)
                    `BYTE_SEL_ADDR0: hit[i] = match_in[i] && !addr0_in;
                    `BYTE_SEL_ADDR1: hit[i] = match_in[i] && addr0_in;
                    default:         hit[i] = match_in[i];
                endcase
            end
        end
    end

    // Lowest-numbered hit takes the shared counter
    logic [IDX_W-1:0] hit_idx;
    logic             any_hit;

    always_comb begin
        hit_idx = '0;
        any_hit = 1'b0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = IDX_W'(i);
                any_hit = 1'b1;
            end
        end
    end

    // Settings of the hitting channel
    ack_field_t hit_field;
    logic       hit_fast;
    logic       hit_ext;

    assign hit_field = ack_timing_in[hit_idx*4 +: 4];
    assign hit_ext   = (hit_field == `ACK_FIELD_EXT)
                       && !autovector_en_in[hit_idx];
    assign hit_fast  = (hit_field == `ACK_FIELD_FAST)
                       || autovector_en_in[hit_idx];

    // Shared wait-state counter
    wait_count_if #(.WIDTH(`ACK_FIELD_W)) ws ();

    wait_counter #(.WIDTH(`ACK_FIELD_W)) u_wait_counter (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .ws     (ws)
    );

    // Sequencer registers
    cycle_state_e        state_reg;
    cycle_state_e        state_next;
    logic [IDX_W-1:0]    sel_reg;
    logic [IDX_W-1:0]    sel_next;
    logic [CHANNELS-1:0] cs_n_reg;
    logic [CHANNELS-1:0] cs_n_next;
    logic                ack_word_reg;
    logic                ack_word_next;
    logic                ack_byte_reg;
    logic                ack_byte_next;
    logic                autovector_request_reg;
    logic                autovector_request_next;
    logic                pend_reg;
    logic                pend_next;
    logic                end_reg;
    logic                end_next;
    logic                fast_reg;
    logic                fast_next;
    logic                upper_reg;
    logic                upper_next;
    logic                lower_reg;
    logic                lower_next;

    // Next-state and output decode
    always_comb begin
        logic             give_ack;
        logic             sel_on;
        logic [IDX_W-1:0] idx;
        state_next    = state_reg;
        sel_next      = sel_reg;
        ack_word_next = ack_word_reg;
        ack_byte_next = ack_byte_reg;
        autovector_request_next     = autovector_request_reg;
        pend_next     = 1'b0;
        end_next      = 1'b0;
        fast_next     = fast_reg;
        give_ack      = 1'b0;
        sel_on        = 1'b0;
        idx           = sel_reg;
        ws.load       = 1'b0;
        ws.value      = hit_field;
        ws.dec        = 1'b0;

        case (state_reg)
            ST_IDLE: begin
                idx = hit_idx;
                if (address_strobe_in && any_hit) begin
                    sel_next = hit_idx;
                    if (mode_e_clock_out_in[hit_idx]) begin
                        // Field ignored, request E-clock slot
                        pend_next  = 1'b1;
                        state_next = ST_E_CLOCK_OUT_PEND;
                    end else if (hit_fast) begin
                        // Ack in S1 clock, S2/S3 dropped
                        give_ack   = 1'b1;
                        fast_next  = 1'b1;
                        sel_on     = 1'b1;
                        state_next = ST_HOLD;
                    end else if (hit_ext) begin
                        sel_on     = 1'b1;
                        state_next = ST_EXT;
                    end else begin
                        ws.load    = 1'b1;
                        sel_on     = 1'b1;
                        state_next = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                sel_on = 1'b1;
                if (ext_ack) begin
                    // External acknowledge cuts the wait short
                    end_next   = 1'b1;
                    state_next = ST_HOLD;
                end else if (ws.zero) begin
                    give_ack   = 1'b1;
                    state_next = ST_HOLD;
                end else begin
                    ws.dec = 1'b1;
                end
            end
            ST_EXT: begin
                // No time-out: only the device ends it
                sel_on = 1'b1;
                if (ext_ack) begin
                    end_next   = 1'b1;
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                sel_on = 1'b1;
                if (!address_strobe_in && !data_strobe_in) begin
                    // Strobes negated in S5
                    ack_word_next = 1'b0;
                    ack_byte_next = 1'b0;
                    autovector_request_next     = 1'b0;
                    fast_next     = 1'b0;
                    sel_on        = 1'b0;
                    state_next    = ST_IDLE;
                end
            end
            ST_E_CLOCK_OUT_PEND: begin
                pend_next = 1'b1;
                if (e_clock_out_ready_in) begin
                    pend_next  = 1'b0;
                    state_next = ST_E_CLOCK_OUT_RUN;
                end
            end
            ST_E_CLOCK_OUT_RUN: begin
                if (e_clock_out_done_in) begin
                    end_next = 1'b1;
                    // Further parts continue without a new slot
                    if (!next_part_in) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase

        // Internal acknowledge by port size or autovector
        if (give_ack) begin
            end_next = 1'b1;
            if (autovector_en_in[idx] && iack_cycle_in) begin
                autovector_request_next = 1'b1;
            end else if (port16_in[idx]) begin
                ack_word_next = 1'b1;
            end else begin
                ack_byte_next = 1'b1;
            end
        end

        // Select asserted with the chosen strobe, or from E-clock ready regardless of strobe, active low
        cs_n_next = {CHANNELS{`CS_N_RESET}};
        // Last part releases the select together with its end pulse
        if ((state_reg == ST_E_CLOCK_OUT_RUN && !(e_clock_out_done_in && !next_part_in))
            || (state_reg == ST_E_CLOCK_OUT_PEND && e_clock_out_ready_in)) begin
            cs_n_next[sel_reg] = 1'b0;
        end else if (sel_on) begin
            if (strobe_select_in[idx] ? data_strobe_in
                                      : address_strobe_in) begin
                cs_n_next[idx] = 1'b0;
            end
        end
    end

    // Byte lane decode from byte count and address bit 0
    always_comb begin
        upper_next = 1'b0;
        lower_next = 1'b0;
        if (address_strobe_in) begin
            case (byte_count_code_in)
                `SIZE_BYTE: begin
                    upper_next = !addr0_in;
                    lower_next = addr0_in;
                end
                default: begin
                    upper_next = !addr0_in;
                    lower_next = 1'b1;
                end
            endcase
        end
    end

    // Register stage for state and all outputs
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg    <= ST_IDLE;
            sel_reg      <= '0;
            cs_n_reg     <= {CHANNELS{`CS_N_RESET}};
            ack_word_reg <= `ACK_RESET;
            ack_byte_reg <= `ACK_RESET;
            autovector_request_reg     <= `ACK_RESET;
            pend_reg     <= 1'b0;
            end_reg      <= 1'b0;
            fast_reg     <= 1'b0;
            upper_reg    <= 1'b0;
            lower_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            sel_reg      <= sel_next;
            cs_n_reg     <= cs_n_next;
            ack_word_reg <= ack_word_next;
            ack_byte_reg <= ack_byte_next;
            autovector_request_reg     <= autovector_request_next;
            pend_reg     <= pend_next;
            end_reg      <= end_next;
            fast_reg     <= fast_next;
            upper_reg    <= upper_next;
            lower_reg    <= lower_next;
        end
    end

    assign cs_n_out               = cs_n_reg;
    assign ack_word_port_out      = ack_word_reg;
    assign ack_byte_port_out      = ack_byte_reg;
    assign autovector_request_out = autovector_request_reg;
    assign e_clock_out_pending_out       = pend_reg;
    assign cycle_end_out          = end_reg;
    assign fast_cycle_out         = fast_reg;
    assign lane_upper_out         = upper_reg;
    assign lane_lower_out         = lower_reg;

endmodule

`default_nettype wire

// >>> tb/cs_partner.sv
`timescale 1ns/1ps
`default_nettype none

module cs_partner #(
    parameter int CHANNELS = 4
) (
    input  wire logic                clk_in,
    input  wire logic [CHANNELS-1:0] cs_n_in,
    input  wire logic                active_in,
    input  wire logic                port16_in,
    input  wire logic [3:0]          delay_in,
    output logic                     ack_word_n_out,
    output logic                     ack_byte_n_out
);
    logic [3:0] count_reg;
    logic       drive;

    // Count clocks spent selected
    always @(posedge clk_in) begin
        if (&cs_n_in) begin
            count_reg <= 4'h0;
        end else if (count_reg != 4'hf) begin
            count_reg <= count_reg + 4'h1;
        end
    end

    // Pulled-up pins, pulled low only while still selected
    assign drive = active_in && !(&cs_n_in)
                   && count_reg >= delay_in;
    assign ack_word_n_out = !(drive && port16_in);
    assign ack_byte_n_out = !(drive && !port16_in);
endmodule

`default_nettype wire

// >>> tb/cs_timing_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cs_timing_chk #(
    parameter int CHANNELS = 12
) (
    input wire logic                clk_in,
    input wire logic                rst_in,
    input wire logic                address_strobe_in,
    input wire logic                data_strobe_in,
    input wire logic                e_clock_out_ready_in,
    input wire logic                e_clock_out_done_in,
    input wire logic                next_part_in,
    input wire logic                ext_ack_word_n_in,
    input wire logic [CHANNELS-1:0] cs_n_out,
    input wire logic                ack_word_port_out,
    input wire logic                ack_byte_port_out,
    input wire logic                autovector_request_out,
    input wire logic                e_clock_out_pending_out,
    input wire logic                cycle_end_out,
    input wire logic                fast_cycle_out
);
    wire logic sel = !(&cs_n_out);
    wire logic ack = ack_word_port_out || ack_byte_port_out;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Selects versus strobes and acknowledges
    chk_idle_high: assert property (
        !$past(address_strobe_in) && !$past(data_strobe_in) |-> &cs_n_out)
        else $error("select low with both strobes idle");
    chk_ack_select: assert property ($rose(ack) |-> sel)
        else $error("acknowledge without a select");
    chk_ack_hold: assert property (
        ack && (address_strobe_in || data_strobe_in) |=> ack)
        else $error("acknowledge dropped while strobes high");
    chk_fast_ack: assert property (
        $rose(fast_cycle_out) |-> ##[0:1] (ack || autovector_request_out))
        else $error("fast cycle without prompt acknowledge");
    chk_ext_end: assert property (
        $fell(ext_ack_word_n_in) && sel && !ack |-> ##[1:4] cycle_end_out)
        else $error("external acknowledge did not end cycle");

    // Peripheral clock cycles
    chk_pend_ready: assert property (
        e_clock_out_pending_out && e_clock_out_ready_in |-> ##[1:2] (sel && !e_clock_out_pending_out))
        else $error("select not given after ready");
    chk_e_clock_out_end: assert property (
        e_clock_out_done_in && !next_part_in && sel |=> cycle_end_out && &cs_n_out)
        else $error("last part did not end cycle");
    chk_e_clock_out_back: assert property (
        e_clock_out_done_in && next_part_in && sel |=> cycle_end_out && sel)
        else $error("select dropped between parts");

    // Main scenarios
    cover property ($rose(fast_cycle_out));
    cover property ($rose(e_clock_out_pending_out));
    cover property (cycle_end_out && !ack && !autovector_request_out);
endmodule

bind cs_timing cs_timing_chk #(.CHANNELS(CHANNELS)) i_chk (
    .clk_in(clk_in), .rst_in(rst_in),
    .address_strobe_in(address_strobe_in), .data_strobe_in(data_strobe_in),
    .e_clock_out_ready_in(e_clock_out_ready_in), .e_clock_out_done_in(e_clock_out_done_in),
    .next_part_in(next_part_in), .ext_ack_word_n_in(ext_ack_word_n_in),
    .cs_n_out(cs_n_out), .ack_word_port_out(ack_word_port_out),
    .ack_byte_port_out(ack_byte_port_out),
    .autovector_request_out(autovector_request_out),
    .e_clock_out_pending_out(e_clock_out_pending_out), .cycle_end_out(cycle_end_out),
    .fast_cycle_out(fast_cycle_out)
);

`default_nettype wire

// >>> tb/cs_timing_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cs_timing_defs.svh"

module cs_timing_bench;
    logic clk_in, rst_in = 1'b1;
    logic [3:0] match_in, mode_e_clock_out_in, strobe_select_in, autovector_en_in;
    logic [3:0] port16_in, cs_n_out, cs_seen, p_delay;
    logic [15:0] ack_timing_in;
    logic [7:0] byte_select_in;
    logic [1:0] byte_count_code_in;
    logic address_strobe_in, data_strobe_in, addr0_in, iack_cycle_in;
    logic e_clock_out_ready_in, e_clock_out_done_in, next_part_in, p_active, p;
    logic ack_word_port_out, ack_byte_port_out, autovector_request_out;
    logic e_clock_out_pending_out, cycle_end_out, fast_cycle_out;
    logic lane_upper_out, lane_lower_out, aw, ab, avq, fst, lup, llo;
    wire logic ext_w_n, ext_b_n;
    wire logic any_ack = ack_word_port_out | ack_byte_port_out
                       | autovector_request_out;
    int errors = 0, samples_checked = 0, seed, i, n, ch, lat, fin;

    cs_timing #(.CHANNELS(4)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .match_in(match_in),
        .mode_e_clock_out_in(mode_e_clock_out_in), .strobe_select_in(strobe_select_in),
        .ack_timing_in(ack_timing_in), .autovector_en_in(autovector_en_in),
        .port16_in(port16_in), .byte_select_in(byte_select_in),
        .address_strobe_in(address_strobe_in),
        .data_strobe_in(data_strobe_in), .addr0_in(addr0_in),
        .byte_count_code_in(byte_count_code_in),
        .iack_cycle_in(iack_cycle_in), .e_clock_out_ready_in(e_clock_out_ready_in),
        .e_clock_out_done_in(e_clock_out_done_in), .next_part_in(next_part_in),
        .ext_ack_word_n_in(ext_w_n), .ext_ack_byte_n_in(ext_b_n),
        .cs_n_out(cs_n_out), .ack_word_port_out(ack_word_port_out),
        .ack_byte_port_out(ack_byte_port_out),
        .autovector_request_out(autovector_request_out),
        .e_clock_out_pending_out(e_clock_out_pending_out), .cycle_end_out(cycle_end_out),
        .fast_cycle_out(fast_cycle_out), .lane_upper_out(lane_upper_out),
        .lane_lower_out(lane_lower_out)
    );
    cs_partner #(.CHANNELS(4)) i_partner (
        .clk_in(clk_in), .cs_n_in(cs_n_out), .active_in(p_active),
        .port16_in(port16_in[3]), .delay_in(p_delay),
        .ack_word_n_out(ext_w_n), .ack_byte_n_out(ext_b_n)
    );

    // Free-running system clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // Result comparisons
    task automatic check_bit(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check_num(input string what, input logic [7:0] e,
                             input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, e, g);
        end
    endtask

    // One channel matching with given field and port width
    task automatic setup(input int c, input logic [3:0] f, input logic w);
        match_in = 4'h1 << c;
        ack_timing_in = 16'h0;
        ack_timing_in[c*4 +: 4] = f;
        port16_in = {4{w}};
        {mode_e_clock_out_in, strobe_select_in, autovector_en_in} = 12'h0;
        byte_select_in = 8'hff;
        {iack_cycle_in, p_active} = 2'h0;
    endtask

    // One strobe cycle, recording when each answer shows
    task automatic access;
        int j;
        lat = 99;
        fin = 99;
        {address_strobe_in, data_strobe_in} = 2'h3;
        for (j = 0; j < 40 && (fin == 99 || j < 3); j++) begin
            @(negedge clk_in);
            if (j == 2) begin
                cs_seen = cs_n_out;
                {lup, llo} = {lane_upper_out, lane_lower_out};
            end
            // Counted in clock edges after the strobe is taken
            if (lat == 99 && any_ack === 1'b1) begin
                lat = j + 1;
                {aw, ab, avq, fst} = {ack_word_port_out, ack_byte_port_out,
                                      autovector_request_out, fast_cycle_out};
            end
            if (fin == 99 && cycle_end_out === 1'b1) fin = j + 1;
        end
        {address_strobe_in, data_strobe_in} = 2'h0;
        repeat (2) @(negedge clk_in);
    endtask

    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #(40 * 8000);
        errors++;
        report_and_stop;
    end

    // Test sequence
    initial begin
        seed = 32'hfd778efd;
        setup(0, 4'h0, 1'b1);
        match_in = 4'h0;
        {address_strobe_in, data_strobe_in, addr0_in} = 3'h0;
        {e_clock_out_ready_in, e_clock_out_done_in, next_part_in} = 3'h0;
        {byte_count_code_in, p_delay} = {`SIZE_WORD, 4'h0};
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        check_num("reset selects", 8'h0f, {4'h0, cs_n_out});
        for (i = 0; i < 6; i++) begin
            n = (i < 2) ? i * 13 : ($random(seed) & 32'hff) % 14;
            ch = $random(seed) & 3;
            p = 1'($random(seed) & 1);
            setup(ch, 4'(n), p);
            access;
            check_num("wait latency", 8'(n + 2), 8'(lat));
            check_bit("word ack", p, aw);
            check_bit("byte ack", !p, ab);
            check_bit("select", 1'b0, cs_seen[ch]);
            if (p) check_bit("lanes", 1'b1, lup & llo);
        end
        $display("test waits done");
        for (i = 0; i < 3; i++) begin
            setup(1, (i == 0) ? `ACK_FIELD_FAST : 4'h9, 1'b1);
            autovector_en_in = (i == 0) ? 4'h0 : 4'hf;
            iack_cycle_in = (i == 2);
            access;
            check_num("fast latency", 8'h01, 8'(lat));
            check_bit("fast flag", 1'b1, fst);
            check_bit("autovector", i == 2, avq);
        end
        $display("test fast done");
        for (i = 0; i < 8; i++) begin
            setup(2, `ACK_FIELD_FAST, 1'b1);
            byte_select_in[5:4] = 2'(i >> 1);
            {addr0_in, byte_count_code_in} = {i[0], `SIZE_BYTE};
            access;
            check_bit("byte gate", byte_select_in[4 + addr0_in],
                      lat == 1);
        end
        {addr0_in, byte_count_code_in} = {1'b0, `SIZE_WORD};
        $display("test byte select done");
        for (i = 0; i < 2; i++) begin
            setup(0, (i == 0) ? 4'h2 : 4'h5, 1'b1);
            ack_timing_in[7:4] = (i == 0) ? 4'h5 : 4'h2;
            match_in = 4'h3;
            access;
            check_num("shared count", (i == 0) ? 8'h04 : 8'h07,
                      8'(lat));
        end
        $display("test shared counter done");
        for (i = 0; i < 2; i++) begin
            setup(3, (i == 0) ? `ACK_FIELD_EXT : 4'hd, 1'b1);
            p_active = 1'b1;
            p_delay = (i == 0) ? 4'h9 : 4'h2;
            access;
            check_bit("no internal ack", 1'b1, lat == 99);
            check_bit("external end", 1'b1,
                      fin < 15 + (1 - i) * 5);
        end
        $display("test external done");
        setup(1, 4'h5, 1'b1);
        strobe_select_in = 4'h2;
        address_strobe_in = 1'b1;
        repeat (3) @(negedge clk_in);
        check_bit("data strobe wait", 1'b1, cs_n_out[1]);
        data_strobe_in = 1'b1;
        repeat (2) @(negedge clk_in);
        check_bit("data strobe select", 1'b0, cs_n_out[1]);
        repeat (6) @(negedge clk_in);
        {address_strobe_in, data_strobe_in} = 2'h0;
        repeat (2) @(negedge clk_in);
        $display("test strobe select done");
        setup(0, 4'h0, 1'b0);
        mode_e_clock_out_in = 4'h1;
        {address_strobe_in, data_strobe_in} = 2'h3;
        repeat (3) @(negedge clk_in);
        check_bit("pending", 1'b1, e_clock_out_pending_out);
        check_bit("held off", 1'b1, cs_n_out[0]);
        e_clock_out_ready_in = 1'b1;
        @(negedge clk_in);
        e_clock_out_ready_in = 1'b0;
        @(negedge clk_in);
        check_bit("clocked select", 1'b0, cs_n_out[0]);
        check_bit("field ignored", 1'b0, ack_byte_port_out);
        for (i = 0; i < 2; i++) begin
            {e_clock_out_done_in, next_part_in} = {1'b1, i == 0};
            @(negedge clk_in);
            {e_clock_out_done_in, address_strobe_in, data_strobe_in} = {1'b0, {2{i == 0}}};
            check_bit("part end", 1'b1, cycle_end_out);
            check_bit("back to back", i == 1, cs_n_out[0]);
            @(negedge clk_in);
        end
        $display("test clocked mode done");
        report_and_stop;
    end
endmodule

`default_nettype wire
